/* logic/tec_boost_decode.sv */
// boost level decoder: bypass flag, clamped level and stage thermometer
`default_nettype none
module tec_boost_decode
  import tec_pkg::*;
#(
  parameter int unsigned STAGES = 8
) (
  // requested level
  input  wire logic [3:0]        level_i,
  // decoded control
  output logic                   bypass_o,
  output logic [3:0]             level_o,
  output logic [STAGES-1:0]      stage_en_o
);
  wire       is_bypass;
  wire       over_max;
  wire [3:0] clamped;

  assign is_bypass = (level_i == TEC_BOOST_BYPASS);
  // undefined codes 9..15 are driven as the strongest setting
  assign over_max  = (level_i > TEC_BOOST_MAX);
  assign clamped   = over_max ? TEC_BOOST_MAX : level_i;

  assign bypass_o  = is_bypass;
  assign level_o   = clamped;

  // one more stage per level step up to 8; codes above 8 enable the same stages as 8
  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      assign stage_en_o[g] = (clamped > 4'(g));
    end
  endgenerate
endmodule : tec_boost_decode
`default_nettype wire

/* logic/tec_config_regs.sv */
// trace equalizer configuration register group with carrier detect hysteresis
// How it works
// - boost field bits 4:1; zero bypasses the equalization stage entirely.
// - boost 1 to 8 selects progressively stronger equalization, up to 17 dB.
// - bit 0 clear gives carrier detect boost 8, set uses programmed boost.
// - assert threshold bits 7:4 of hysteresis register, range 0 to 15, reset 4.
// - deassert threshold bits 3:0 of hysteresis register, range 0 to 15, reset 3.
`default_nettype none
module tec_config_regs
  import tec_pkg::*;
#(
  parameter int unsigned STAGES = 8
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  // register access port from the serial control interface
  input  wire logic [TEC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [TEC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [TEC_DATA_W-1:0] reg_rdata_o,
  output logic                       reg_rvalid_o,
  // signal level from the analog carrier detector, asynchronous
  input  wire logic [3:0]            sig_level_i,
  // trace equalizer controls
  output logic                       eq_bypass_o,
  output logic      [3:0]            eq_boost_level_o,
  output logic      [STAGES-1:0]     eq_stage_en_o,
  // carrier detect controls and status
  output logic      [3:0]            cd_boost_level_o,
  output logic      [STAGES-1:0]     cd_stage_en_o,
  output logic      [3:0]            carrier_assert_level_o,
  output logic      [3:0]            carrier_deassert_level_o,
  output logic                       carrier_detect_o
);

  // decode helpers
  function automatic logic addr_hit(input logic [TEC_ADDR_W-1:0] a);
    addr_hit = (a >= TEC_FIRST_OFS) && (a <= TEC_LAST_OFS);
  endfunction : addr_hit

  function automatic logic [TEC_IDX_W-1:0] addr_idx(input logic [TEC_ADDR_W-1:0] a);
    logic [TEC_ADDR_W-1:0] d;
    d = a - TEC_FIRST_OFS;
    addr_idx = d[TEC_IDX_W-1:0];
  endfunction : addr_idx

  // register storage; every bit is kept, reserved ones included
  logic [TEC_DATA_W-1:0] regs [TEC_NUM_REGS];

  wire                  hit;
  wire [TEC_IDX_W-1:0]  idx;
  wire                  wr_en;
  wire [TEC_DATA_W-1:0] rd_word;

  assign hit     = addr_hit(reg_addr_i);
  assign idx     = addr_idx(reg_addr_i);
  // unmapped writes are dropped and unmapped reads return zero
  assign wr_en   = reg_wr_i && hit;
  assign rd_word = hit ? regs[idx] : TEC_UNMAPPED_READ;

  // reserved registers stay fully readable and writable
  genvar r;
  generate
    for (r = 0; r < TEC_NUM_REGS; r++) begin : g_reg
      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          regs[r] <= TEC_RESET_VALUES[r*16 +: 16];
        end else if (wr_en && (idx == TEC_IDX_W'(r))) begin
          regs[r] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // read data one cycle after the strobe; a write in the same cycle is not seen
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_word;
      end
    end
  end

  // field extraction
  localparam logic [TEC_ADDR_W-1:0] BOOST_REG_OFS = TEC_EQUALIZER_BOOST_CONTROL_OFS;
  localparam logic [TEC_ADDR_W-1:0] HYST_REG_OFS  = TEC_CARRIER_DETECT_HYST_OFS;

  wire [TEC_DATA_W-1:0] boost_reg;
  wire [TEC_DATA_W-1:0] hyst_reg;
  wire [3:0]            eq_boost_level;
  wire                  carrier_boost_select;
  wire [3:0]            carrier_assert_level;
  wire [3:0]            carrier_deassert_level;
  wire [3:0]            cd_level_req;

  assign boost_reg              = regs[addr_idx(BOOST_REG_OFS)];
  assign hyst_reg               = regs[addr_idx(HYST_REG_OFS)];
  assign eq_boost_level         = boost_reg[TEC_BOOST_MSB:TEC_BOOST_LSB];
  assign carrier_boost_select   = boost_reg[TEC_CD_BOOST_SEL];
  assign carrier_assert_level   = hyst_reg[TEC_ASSERT_MSB:TEC_ASSERT_LSB];
  assign carrier_deassert_level = hyst_reg[TEC_DEASSERT_MSB:TEC_DEASSERT_LSB];
  assign cd_level_req           = carrier_boost_select ? eq_boost_level : TEC_BOOST_MAX;

  // boost decoding for the data path and for carrier detection
  wire              eq_bypass;
  wire [3:0]        eq_level;
  wire [STAGES-1:0] eq_stage_en;
  wire              cd_bypass;
  wire [3:0]        cd_level;
  wire [STAGES-1:0] cd_stage_en;

  tec_boost_decode #(
    .STAGES     (STAGES)
  ) u_eq_decode (
    .level_i    (eq_boost_level),
    .bypass_o   (eq_bypass),
    .level_o    (eq_level),
    .stage_en_o (eq_stage_en)
  );

  tec_boost_decode #(
    .STAGES     (STAGES)
  ) u_cd_decode (
    .level_i    (cd_level_req),
    .bypass_o   (cd_bypass),
    .level_o    (cd_level),
    .stage_en_o (cd_stage_en)
  );

  // bypass on the carrier path shows only as all stages off
  wire unused_cd_bypass;
  assign unused_cd_bypass = cd_bypass;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eq_bypass_o      <= 1'b0;
      eq_boost_level_o <= 4'h0;
      eq_stage_en_o    <= '0;
    end else begin
      eq_bypass_o      <= eq_bypass;
      eq_boost_level_o <= eq_level;
      eq_stage_en_o    <= eq_bypass ? '0 : eq_stage_en;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cd_boost_level_o         <= 4'h0;
      cd_stage_en_o            <= '0;
      carrier_assert_level_o   <= 4'h0;
      carrier_deassert_level_o <= 4'h0;
    end else begin
      cd_boost_level_o         <= cd_level;
      cd_stage_en_o            <= cd_stage_en;
      carrier_assert_level_o   <= carrier_assert_level;
      carrier_deassert_level_o <= carrier_deassert_level;
    end
  end

  // level synchroniser; a new value is taken once stages two and three agree
  logic [3:0] lvl_s1;
  logic [3:0] lvl_s2;
  logic [3:0] lvl_s3;
  logic [3:0] lvl_held;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_s1 <= 4'h0;
      lvl_s2 <= 4'h0;
      lvl_s3 <= 4'h0;
    end else begin
      lvl_s1 <= sig_level_i;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
    end
  end

  wire lvl_stable;
  assign lvl_stable = (lvl_s2 == lvl_s3);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_held <= 4'h0;
    end else if (lvl_stable) begin
      lvl_held <= lvl_s3;
    end
  end

  // carrier detect with hysteresis between the two thresholds
  tec_cd_state_e cd_state;
  tec_cd_state_e next_cd_state;

  wire at_assert;
  wire below_deassert;
  assign at_assert      = (lvl_held >= carrier_assert_level);
  assign below_deassert = (lvl_held <  carrier_deassert_level);

  always_comb begin
    next_cd_state = cd_state;
    case (cd_state)
      TEC_CD_ABSENT: begin
        if (at_assert) begin
          next_cd_state = TEC_CD_PRESENT;
        end
      end
      TEC_CD_PRESENT: begin
        if (below_deassert) begin
          next_cd_state = TEC_CD_ABSENT;
        end
      end
      default: begin
        next_cd_state = TEC_CD_ABSENT;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cd_state         <= TEC_CD_ABSENT;
      carrier_detect_o <= 1'b0;
    end else begin
      cd_state         <= next_cd_state;
      carrier_detect_o <= (next_cd_state == TEC_CD_PRESENT);
    end
  end

endmodule : tec_config_regs
`default_nettype wire

/* logic/tec_pkg.sv */
// constants for the trace equalizer configuration register group
`default_nettype none
package tec_pkg;
  localparam int unsigned TEC_ADDR_W     = 8;
  localparam int unsigned TEC_DATA_W     = 16;
  localparam int unsigned TEC_NUM_REGS   = 14;
  localparam int unsigned TEC_IDX_W      = 4;

  // register offsets
  localparam logic [7:0] TEC_RESERVED_EQ_A_OFS          = 8'h14;
  localparam logic [7:0] TEC_RESERVED_EQ_B_OFS          = 8'h15;
  localparam logic [7:0] TEC_RESERVED_EQ_C_OFS          = 8'h16;
  localparam logic [7:0] TEC_RESERVED_EQ_D_OFS          = 8'h17;
  localparam logic [7:0] TEC_RESERVED_EQ_E_OFS          = 8'h18;
  localparam logic [7:0] TEC_RESERVED_EQ_F_OFS          = 8'h19;
  localparam logic [7:0] TEC_RESERVED_EQ_G_OFS          = 8'h1A;
  localparam logic [7:0] TEC_RESERVED_EQ_H_OFS          = 8'h1B;
  localparam logic [7:0] TEC_RESERVED_EQ_I_OFS          = 8'h1C;
  localparam logic [7:0] TEC_RESERVED_EQ_J_OFS          = 8'h1D;
  localparam logic [7:0] TEC_EQUALIZER_BOOST_CONTROL_OFS = 8'h1E;
  localparam logic [7:0] TEC_CARRIER_DETECT_HYST_OFS     = 8'h1F;
  localparam logic [7:0] TEC_RESERVED_EQ_K_OFS          = 8'h20;
  localparam logic [7:0] TEC_RESERVED_EQ_L_OFS          = 8'h21;
  localparam logic [7:0] TEC_FIRST_OFS                  = TEC_RESERVED_EQ_A_OFS;
  localparam logic [7:0] TEC_LAST_OFS                   = TEC_RESERVED_EQ_L_OFS;

  // reset values, indexed by offset minus first offset
  localparam logic [TEC_NUM_REGS*16-1:0] TEC_RESET_VALUES = {
    16'h000F, 16'h0003, 16'h0043, 16'h0004,
    16'h0000, 16'h0004, 16'h0001, 16'h0014,
    16'h0001, 16'h0050, 16'h0001, 16'h4002,
    16'h0000, 16'h0303
  };

  // equalizer_boost_control fields
  localparam int unsigned TEC_BOOST_LSB      = 1;
  localparam int unsigned TEC_BOOST_MSB      = 4;
  localparam int unsigned TEC_CD_BOOST_SEL   = 0;
  localparam logic [3:0]  TEC_BOOST_BYPASS   = 4'h0;
  localparam logic [3:0]  TEC_BOOST_MAX      = 4'h8;

  // carrier_detect_hysteresis fields
  localparam int unsigned TEC_ASSERT_LSB     = 4;
  localparam int unsigned TEC_ASSERT_MSB     = 7;
  localparam int unsigned TEC_DEASSERT_LSB   = 0;
  localparam int unsigned TEC_DEASSERT_MSB   = 3;

  localparam logic [15:0] TEC_UNMAPPED_READ  = 16'h0000;

  typedef enum logic [1:0] {
    TEC_CD_ABSENT  = 2'b01,
    TEC_CD_PRESENT = 2'b10
  } tec_cd_state_e;
endpackage : tec_pkg
`default_nettype wire

/* verif/tec_config_regs_sva.sv */
// concurrent checks on the trace equalizer configuration register ports
`default_nettype none
module tec_config_regs_sva
  import tec_pkg::*;
#(
  parameter int unsigned STAGES = 8
) (
  input wire logic                  core_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic [TEC_ADDR_W-1:0] reg_addr_i,
  input wire logic [TEC_DATA_W-1:0] reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [TEC_DATA_W-1:0] reg_rdata_o,
  input wire logic                  reg_rvalid_o,
  input wire logic [3:0]            sig_level_i,
  input wire logic                  eq_bypass_o,
  input wire logic [3:0]            eq_boost_level_o,
  input wire logic [STAGES-1:0]     eq_stage_en_o,
  input wire logic [3:0]            cd_boost_level_o,
  input wire logic [STAGES-1:0]     cd_stage_en_o,
  input wire logic [3:0]            carrier_assert_level_o,
  input wire logic [3:0]            carrier_deassert_level_o,
  input wire logic                  carrier_detect_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire wr_boost = reg_wr_i && reg_addr_i == TEC_EQUALIZER_BOOST_CONTROL_OFS;
  wire wr_hyst  = reg_wr_i && reg_addr_i == TEC_CARRIER_DETECT_HYST_OFS;
  wire mapped   = reg_addr_i >= TEC_FIRST_OFS && reg_addr_i <= TEC_LAST_OFS;
  AST_WR_BYPASS:
  assert property (wr_boost |-> ##2 eq_bypass_o == ($past(reg_wdata_i[4:1], 2) == 4'h0)) else $error("bypass flag wrong");
  AST_WR_BOOST:
  assert property (wr_boost |-> ##2 eq_boost_level_o ==
    (($past(reg_wdata_i[4:1], 2) > 4'h8) ? 4'h8 : $past(reg_wdata_i[4:1], 2))) else $error("boost level wrong");
  AST_STAGE:
  assert property (eq_stage_en_o == STAGES'((16'h1 << eq_boost_level_o) - 16'h1)) else $error("stage enables wrong");
  AST_CD_MAX:
  assert property (wr_boost && !reg_wdata_i[0] |-> ##2 cd_boost_level_o == 4'h8) else $error("carrier boost not max");
  AST_CD_PROG:
  assert property (wr_boost && reg_wdata_i[0] |-> ##2 cd_boost_level_o == eq_boost_level_o) else $error("carrier boost wrong");
  AST_ASSERT_LVL:
  assert property (wr_hyst |-> ##2 carrier_assert_level_o == $past(reg_wdata_i[7:4], 2)) else $error("assert level wrong");
  AST_DEASSERT_LVL:
  assert property (wr_hyst |-> ##2 carrier_deassert_level_o == $past(reg_wdata_i[3:0], 2)) else $error("deassert level wrong");
  AST_RVALID:
  assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  AST_RDATA:
  assert property (reg_wr_i && mapped ##1 !reg_wr_i && !reg_rd_i && $stable(reg_addr_i)
    ##1 reg_rd_i && !reg_wr_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("read back differs from write");
  AST_CD_RISE:
  assert property ((!reg_wr_i && $stable(sig_level_i) && sig_level_i >= carrier_assert_level_o
    && carrier_assert_level_o >= carrier_deassert_level_o) [*6] |-> carrier_detect_o) else $error("carrier not set");
  AST_CD_FALL:
  assert property ((!reg_wr_i && $stable(sig_level_i) && sig_level_i < carrier_deassert_level_o
    && sig_level_i < carrier_assert_level_o) [*6]
    |-> !carrier_detect_o) else $error("carrier not cleared");
endmodule : tec_config_regs_sva
bind tec_config_regs tec_config_regs_sva #(.STAGES(STAGES)) sva_u (.core_clk_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .sig_level_i, .eq_bypass_o, .eq_boost_level_o,
  .eq_stage_en_o, .cd_boost_level_o, .cd_stage_en_o, .carrier_assert_level_o, .carrier_deassert_level_o,
  .carrier_detect_o);
`default_nettype wire

/* verif/tec_config_regs_tb.sv */
// self-checking bench for the trace equalizer configuration registers
`default_nettype none
module tec_config_regs_tb import tec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, rvalid, byp, cdet;
  logic [7:0]  addr, eqs, cds;
  logic [15:0] wdata, rdata;
  logic [3:0]  sig, eql, cdl, asl, dsl;
  int          n_errors, cmp_count;
  tec_config_regs dut_u (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sig_level_i(sig),
    .eq_bypass_o(byp), .eq_boost_level_o(eql), .eq_stage_en_o(eqs), .cd_boost_level_o(cdl),
    .cd_stage_en_o(cds), .carrier_assert_level_o(asl), .carrier_deassert_level_o(dsl), .carrier_detect_o(cdet));
  function automatic logic [3:0] clamp(input logic [3:0] v);
    return (v > 4'h8) ? 4'h8 : v;
  endfunction : clamp
  function automatic logic [15:0] thermo(input logic [3:0] l);
    return (16'h1 << l) - 16'h1;
  endfunction : thermo
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // both bus tasks start and end at a falling edge; one idle edge follows each strobe,
  // which also lets the registered decode outputs catch up with a write
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk_out(16'(rvalid), 16'h0001);
    chk_rd(rdata, exp);
    @(negedge clk);
  endtask : rd_reg
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    logic [3:0] v, a, d;
    logic       b, cexp;
    rst = 1'b1;
    {wr, rd, addr, wdata, sig, cexp} = '0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(83927));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_out({byp, 3'h0, eql, cdl, asl}, 16'h0284);
    chk_out(16'(dsl), 16'h0003);
    // reserved places are written only with their own reset contents
    for (int i = 0; i < TEC_NUM_REGS; i++) begin
      rd_reg(TEC_FIRST_OFS + 8'(i), TEC_RESET_VALUES[i*16 +: 16]);
      wr_reg(TEC_FIRST_OFS + 8'(i), TEC_RESET_VALUES[i*16 +: 16]);
      rd_reg(TEC_FIRST_OFS + 8'(i), TEC_RESET_VALUES[i*16 +: 16]);
    end
    wr_reg(8'h22, 16'hA5A5);
    rd_reg(8'h22, 16'h0000);
    rd_reg(8'h13, 16'h0000);
    for (int j = 0; j < 32; j++) begin
      v = 4'(j >> 1);
      b = j[0];
      wr_reg(TEC_EQUALIZER_BOOST_CONTROL_OFS, {11'h000, v, b});
      chk_out(16'(byp), 16'(v == 4'h0));
      chk_out({eqs, 4'h0, eql}, {8'(thermo(clamp(v))), 4'h0, clamp(v)});
      chk_out({cds, 4'h0, cdl}, b ? {8'(thermo(clamp(v))), 4'h0, clamp(v)} : 16'hFF08);
      rd_reg(TEC_EQUALIZER_BOOST_CONTROL_OFS, {11'h000, v, b});
    end
    for (int k = 0; k < 40; k++) begin
      a = (k == 0) ? 4'hF : 4'($urandom_range(15, 0));
      d = (k == 0) ? 4'h0 : 4'($urandom_range(a, 0));
      wr_reg(TEC_CARRIER_DETECT_HYST_OFS, {8'h00, a, d});
      chk_out({asl, dsl}, {8'h00, a, d});
      repeat (6) @(negedge clk);
      cexp = (sig >= a) ? 1'b1 : (sig < d) ? 1'b0 : cexp;
      sig = (k % 5 == 1) ? a : 4'($urandom_range(15, 0));
      repeat (6) @(negedge clk);
      cexp = (sig >= a) ? 1'b1 : (sig < d) ? 1'b0 : cexp;
      chk_out(16'(cdet), 16'(cexp));
      rd_reg(TEC_CARRIER_DETECT_HYST_OFS, {8'h00, a, d});
    end
    end_sim();
  end
endmodule : tec_config_regs_tb
`default_nettype wire
